// ==== hw/ics_pkg.sv ====
// Constants, register map and field layout of the injection command sequencer.
package ics_pkg;

  // ********************************
  // Clock and timing
  // ********************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int NUM_LINES = 10;
  localparam int NUM_CHAN = 20;
  localparam int PULL_STEP_NS = 100000;
  localparam int PULL_STEP_CYC_I = PULL_STEP_NS / CLK_PERIOD_NS;
  localparam logic [17:0] PULL_STEP_CYC = 18'(PULL_STEP_CYC_I);
  localparam logic [7:0] PULL_MIN_UNITS = 8'h0a;
  localparam logic [7:0] PULL_MAX_UNITS = 8'h28;
  localparam logic [7:0] PULL_RST_UNITS = 8'h0a;
  localparam int HOLD_LIMIT_MS = 450;
  localparam int HOLD_LIMIT_CYC = HOLD_LIMIT_MS * (1000000 / CLK_PERIOD_NS);
  localparam int SIM_RPM_X10 = 375;
  localparam int SIM_TEETH = 60;
  localparam int SIM_TOOTH_US = 600000000 / (SIM_RPM_X10 * SIM_TEETH);
  localparam int SIM_TOOTH_CYC = SIM_TOOTH_US * (1000 / CLK_PERIOD_NS);
  localparam logic [5:0] SIM_LAST_TOOTH = 6'(SIM_TEETH - 1);
  localparam int WDOG_TIMEOUT_MS = 100;
  localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);
  localparam int PWM_PERIOD_US = 50;
  localparam int PWM_PERIOD_CYC_I = PWM_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam logic [9:0] PWM_PERIOD_CYC = 10'(PWM_PERIOD_CYC_I);

  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PULL = 8'h04;
  localparam logic [7:0] REG_KICK = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_EN = 8'h14;
  localparam logic [7:0] REG_IRQ_CLR = 8'h18;
  localparam logic [7:0] REG_DOUT = 8'h1c;
  localparam logic [7:0] REG_CHAN_ACT = 8'h20;
  localparam int MMIO_BIT = 7;
  localparam int MMIO_SEL_LO = 5;

  // ********************************
  // Fields
  // ********************************
  localparam int CTRL_TEST = 0;
  localparam int CTRL_FOUR = 1;
  localparam int CTRL_RESYNC = 2;
  localparam int STAT_HALT = 0;
  localparam int STAT_INHIBIT = 1;
  localparam int IRQ_WDOG = 0;
  localparam int IRQ_LIMIT = 1;
  localparam int IRQ_MARK = 2;
  localparam int IRQ_W = 3;
  localparam int DOUT_ONE = 0;
  localparam int DOUT_TWO = 1;

  typedef enum logic [3:0] {
    CH_IDLE = 4'b0001,
    CH_PULL = 4'b0010,
    CH_HOLD = 4'b0100,
    CH_DONE = 4'b1000
  } ics_chan_state_e;

endpackage

// ==== hw/ics_channel.sv ====
// One solenoid driver channel: pull-in timer, hold-in limit and hold current PWM.
`timescale 1ns/1ps
module ics_channel
  import ics_pkg::*;
#(
  parameter int HOLD_CYC = HOLD_LIMIT_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Command and control
  input wire logic i_cmd,
  input wire logic i_inhibit,
  input wire logic [17:0] i_pull_cyc,
  input wire logic i_cur_over,
  // Driver outputs
  output logic o_energize,
  output logic o_full_current,
  output logic o_drive_gate,
  output logic o_limit_hit
);

  ics_chan_state_e state_q;
  logic [17:0] pull_cnt_q;
  logic [22:0] hold_cnt_q;
  logic [9:0] pwm_cnt_q;
  logic [9:0] pwm_width_q;

  // ********************************
  // Timers and state
  // ********************************
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_inhibit) begin
      state_q <= CH_IDLE;
      pull_cnt_q <= '0;
      hold_cnt_q <= '0;
      o_limit_hit <= 1'b0;
    end else begin
      o_limit_hit <= 1'b0;
      case (state_q)
        CH_IDLE: begin
          if (i_cmd) begin
            state_q <= CH_PULL;
            pull_cnt_q <= 18'h00001;
            hold_cnt_q <= 23'h000001;
          end
        end
        CH_PULL, CH_HOLD: begin
          hold_cnt_q <= hold_cnt_q + 23'h000001;
          pull_cnt_q <= pull_cnt_q + 18'h00001;
          if (!i_cmd) begin
            state_q <= CH_IDLE;
          end else if (hold_cnt_q >= 23'(HOLD_CYC)) begin
            state_q <= CH_DONE;
            o_limit_hit <= 1'b1;
          end else if (state_q == CH_PULL && pull_cnt_q >= i_pull_cyc) begin
            state_q <= CH_HOLD;
          end
        end
        CH_DONE: begin
          if (!i_cmd) begin
            state_q <= CH_IDLE;
          end
        end
        default: begin
          state_q <= CH_IDLE;
        end
      endcase
    end
  end

  // ********************************
  // Hold current regulation
  // ********************************
  // current feedback trims width.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || state_q != CH_HOLD) begin
      pwm_cnt_q <= '0;
      pwm_width_q <= PWM_PERIOD_CYC;
    end else if (pwm_cnt_q == PWM_PERIOD_CYC - 10'h001) begin
      pwm_cnt_q <= '0;
      if (i_cur_over && pwm_width_q != '0) begin
        pwm_width_q <= pwm_width_q - 10'h001;
      end else if (!i_cur_over && pwm_width_q != PWM_PERIOD_CYC) begin
        pwm_width_q <= pwm_width_q + 10'h001;
      end
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_inhibit) begin
      o_energize <= 1'b0;
      o_full_current <= 1'b0;
      o_drive_gate <= 1'b0;
    end else begin
      o_energize <= state_q == CH_PULL || state_q == CH_HOLD;
      o_full_current <= state_q == CH_PULL;
      o_drive_gate <= state_q == CH_PULL || (state_q == CH_HOLD && pwm_cnt_q < pwm_width_q);
    end
  end

endmodule

// ==== hw/ics_top.sv ====
// Injection command sequencer: demultiplexer, timing marks, watchdog, test wheel, decode, indicators.
`timescale 1ns/1ps
// Overview of operation
// - Split ten shared processor injection lines into twenty per-cylinder commands.
// - A channel energizes while its cylinder command is asserted, until the hold-in limit ends it.
// - Pull-in and hold-in limit timers start on the command's leading edge.
// - Pull-in interval is programmable from 1 to 4 ms with full current.
// - Energizing ends 450 ms after command start even if command persists.
// - After pull-in, current feedback shortens PWM pulses to hold current.
// - Watchdog fault halts the processor and inhibits the injector drivers and discrete outputs.
// - Test mode simulates 37.5 rpm on a 60-tooth wheel.
// - Decode setup commands to this block and memory-mapped I/O selects.
// - Run indicator lit while executing, dark from halt until restart.
// - Each discrete-output indicator is lit exactly while its output is high.
// - Network indicator lights while network activity is present.
// - Four-stroke forwards only the first top mark after phase; two-stroke ignores phase.
module ics_top
  import ics_pkg::*;
#(
  parameter int HOLD_CYC = HOLD_LIMIT_CYC,
  parameter int TOOTH_CYC = SIM_TOOTH_CYC,
  parameter int WDOG_CYC = WDOG_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Memory-mapped I/O
  output logic [3:0] o_mmio_sel,
  output logic o_mmio_wr,
  output logic o_mmio_rd,
  input wire logic [31:0] i_mmio_rdata,
  // Processor and engine pins
  input wire logic [NUM_LINES-1:0] i_inj_line,
  input wire logic i_speed_pin,
  input wire logic i_tdc_pin,
  input wire logic i_phase_pin,
  input wire logic i_cpu_restart,
  input wire logic i_net_activity,
  input wire logic [NUM_CHAN-1:0] i_cur_over,
  // Timing to processor
  output logic o_speed_to_cpu,
  output logic o_top_center_mark,
  // Drivers
  output logic [NUM_CHAN-1:0] o_fire,
  output logic [NUM_CHAN-1:0] o_full_current,
  output logic [NUM_CHAN-1:0] o_drive_gate,
  // Watchdog and indicators
  output logic o_cpu_halt,
  output logic o_io_inhibit,
  output logic o_discrete_out_one,
  output logic o_discrete_out_two,
  output logic o_run_led,
  output logic o_net_led,
  output logic o_do_one_led,
  output logic o_do_two_led,
  output logic o_irq
);

  localparam int SW = NUM_LINES + 5 + NUM_CHAN;

  logic [SW-1:0] pin_a_q, pin_b_q, pin_c_q, pin_f_q, pin_p_q;
  logic [NUM_LINES-1:0] line_f, line_fall, bank_q;
  logic [NUM_CHAN-1:0] cmd, limit_hit;
  logic speed_f, tdc_rise, phase_rise, restart_f;
  logic test_q, four_q, armed_q, halt_q;
  logic [7:0] pull_units_q, pull_units;
  logic [17:0] pull_cyc;
  logic [1:0] dout_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_en_q, irq_set;
  logic [22:0] wdog_cnt_q;
  logic [18:0] tooth_cnt_q;
  logic [5:0] tooth_q;
  logic sim_tick, sim_tdc, sim_tick_q;
  logic reg_hit;
  logic [31:0] rd_mux;

  // ********************************
  // Pin synchronisers
  // ********************************
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pin_a_q <= '0;
      pin_b_q <= '0;
      pin_c_q <= '0;
      pin_f_q <= '0;
      pin_p_q <= '0;
    end else begin
      pin_a_q <= {i_cur_over, i_net_activity, i_cpu_restart, i_phase_pin, i_tdc_pin, i_speed_pin, i_inj_line};
      pin_b_q <= pin_a_q;
      pin_c_q <= pin_b_q;
      pin_f_q <= (pin_b_q & pin_c_q) | (pin_f_q & (pin_b_q ^ pin_c_q));
      pin_p_q <= pin_f_q;
    end
  end

  assign line_f = pin_f_q[NUM_LINES-1:0];
  assign line_fall = pin_p_q[NUM_LINES-1:0] & ~line_f;
  assign speed_f = pin_f_q[NUM_LINES];
  assign tdc_rise = pin_f_q[NUM_LINES+1] & ~pin_p_q[NUM_LINES+1];
  assign phase_rise = pin_f_q[NUM_LINES+2] & ~pin_p_q[NUM_LINES+2];
  assign restart_f = pin_f_q[NUM_LINES+3];

  // ********************************
  // Demultiplexer
  // ********************************
  // events alternate per line.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || o_io_inhibit) begin
      bank_q <= '0;
    end else if (i_reg_wr && i_reg_addr == REG_CTRL && i_reg_wdata[CTRL_RESYNC]) begin
      bank_q <= '0;
    end else begin
      bank_q <= bank_q ^ line_fall;
    end
  end

  generate
    for (genvar k = 0; k < NUM_LINES; k++) begin : g_demux
      assign cmd[2*k] = line_f[k] & ~bank_q[k] & ~o_io_inhibit;
      assign cmd[2*k+1] = line_f[k] & bank_q[k] & ~o_io_inhibit;
    end
  endgenerate

  assign pull_units = (pull_units_q < PULL_MIN_UNITS) ? PULL_MIN_UNITS :
                      (pull_units_q > PULL_MAX_UNITS) ? PULL_MAX_UNITS : pull_units_q;
  assign pull_cyc = 18'(pull_units * PULL_STEP_CYC);

  generate
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
      ics_channel #(
        .HOLD_CYC(HOLD_CYC)
      ) u_chan (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_cmd(cmd[c]),
        .i_inhibit(o_io_inhibit),
        .i_pull_cyc(pull_cyc),
        .i_cur_over(pin_f_q[NUM_LINES+5+c]),
        .o_energize(o_fire[c]),
        .o_full_current(o_full_current[c]),
        .o_drive_gate(o_drive_gate[c]),
        .o_limit_hit(limit_hit[c])
      );
    end
  endgenerate

  // ********************************
  // Test wheel and timing mark
  // ********************************
  // simulated 60-tooth wheel.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !test_q) begin
      tooth_cnt_q <= '0;
      tooth_q <= '0;
    end else if (sim_tick) begin
      tooth_cnt_q <= '0;
      tooth_q <= (tooth_q == SIM_LAST_TOOTH) ? 6'h00 : tooth_q + 6'h01;
    end else begin
      tooth_cnt_q <= tooth_cnt_q + 19'h00001;
    end
  end

  assign sim_tick = test_q && tooth_cnt_q == 19'(TOOTH_CYC - 1);
  assign sim_tdc = sim_tick && tooth_q == SIM_LAST_TOOTH;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      armed_q <= 1'b0;
      o_top_center_mark <= 1'b0;
      o_speed_to_cpu <= 1'b0;
      sim_tick_q <= 1'b0;
    end else begin
      sim_tick_q <= sim_tick;
      o_speed_to_cpu <= test_q ? sim_tick_q : speed_f;
      if (test_q) begin
        o_top_center_mark <= sim_tdc;
        armed_q <= 1'b0;
      end else if (four_q) begin
        o_top_center_mark <= tdc_rise && armed_q;
        armed_q <= phase_rise ? 1'b1 : (tdc_rise ? 1'b0 : armed_q);
      end else begin
        o_top_center_mark <= tdc_rise;
        armed_q <= 1'b0;
      end
    end
  end

  // ********************************
  // Watchdog
  // ********************************
  // fault halts and inhibits.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wdog_cnt_q <= '0;
      halt_q <= 1'b0;
    end else if (halt_q) begin
      wdog_cnt_q <= '0;
      halt_q <= ~restart_f;
    end else if (i_reg_wr && i_reg_addr == REG_KICK) begin
      wdog_cnt_q <= '0;
    end else if (wdog_cnt_q == 23'(WDOG_CYC - 1)) begin
      halt_q <= 1'b1;
    end else begin
      wdog_cnt_q <= wdog_cnt_q + 23'h000001;
    end
  end

  assign o_cpu_halt = halt_q;
  assign o_io_inhibit = halt_q;

  // ********************************
  // Setup registers
  // ********************************
  // setup command decode.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      test_q <= 1'b0;
      four_q <= 1'b0;
      pull_units_q <= PULL_RST_UNITS;
      dout_q <= '0;
      irq_en_q <= '0;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        REG_CTRL: begin
          test_q <= i_reg_wdata[CTRL_TEST];
          four_q <= i_reg_wdata[CTRL_FOUR];
        end
        REG_PULL: pull_units_q <= i_reg_wdata[7:0];
        REG_DOUT: dout_q <= i_reg_wdata[1:0];
        REG_IRQ_EN: irq_en_q <= i_reg_wdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  assign irq_set = {o_top_center_mark, |limit_hit, halt_q};

  // Set wins over a clear in the same cycle.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      irq_stat_q <= '0;
    end else if (i_reg_wr && i_reg_addr == REG_IRQ_CLR) begin
      irq_stat_q <= (irq_stat_q & ~i_reg_wdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  assign o_irq = |(irq_stat_q & irq_en_q);

  // ********************************
  // Read path and I/O decode
  // ********************************
  assign reg_hit = ~i_reg_addr[MMIO_BIT];
  assign o_mmio_sel = i_reg_addr[MMIO_BIT] ? 4'h1 << i_reg_addr[MMIO_SEL_LO+:2] : 4'h0;
  assign o_mmio_wr = i_reg_addr[MMIO_BIT] & i_reg_wr;
  assign o_mmio_rd = i_reg_addr[MMIO_BIT] & i_reg_rd;

  always_comb begin
    rd_mux = '0;
    case (i_reg_addr)
      REG_CTRL: rd_mux = {30'h0, four_q, test_q};
      REG_PULL: rd_mux = {24'h0, pull_units_q};
      REG_STAT: rd_mux = {30'h0, o_io_inhibit, halt_q};
      REG_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
      REG_IRQ_EN: rd_mux = {29'h0, irq_en_q};
      REG_DOUT: rd_mux = {30'h0, dout_q};
      REG_CHAN_ACT: rd_mux = {12'h0, o_fire};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= '0;
    end else begin
      o_reg_rdata <= (i_reg_rd && reg_hit) ? rd_mux : 32'h0;
    end
  end

  // ********************************
  // Outputs and indicators
  // ********************************
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_discrete_out_one <= 1'b0;
      o_discrete_out_two <= 1'b0;
      o_run_led <= 1'b0;
      o_net_led <= 1'b0;
    end else begin
      o_discrete_out_one <= dout_q[DOUT_ONE] & ~o_io_inhibit;
      o_discrete_out_two <= dout_q[DOUT_TWO] & ~o_io_inhibit;
      o_run_led <= ~halt_q;
      o_net_led <= pin_f_q[NUM_LINES+4];
    end
  end

  assign o_do_one_led = o_discrete_out_one;
  assign o_do_two_led = o_discrete_out_two;

endmodule

// ==== testbench/ics_monitor.sv ====
// Concurrent checks on the sequencer top ports.
`timescale 1ns/1ps
module ics_monitor
  import ics_pkg::*;
#(
  parameter int HOLD_CYC = HOLD_LIMIT_CYC,
  parameter int TOOTH_CYC = SIM_TOOTH_CYC,
  parameter int WDOG_CYC = WDOG_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Watched ports
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [3:0] o_mmio_sel,
  input wire logic o_mmio_wr,
  input wire logic o_mmio_rd,
  input wire logic [NUM_LINES-1:0] i_inj_line,
  input wire logic [NUM_CHAN-1:0] o_fire,
  input wire logic [NUM_CHAN-1:0] o_full_current,
  input wire logic [NUM_CHAN-1:0] o_drive_gate,
  input wire logic o_top_center_mark,
  input wire logic o_cpu_halt,
  input wire logic o_io_inhibit,
  input wire logic o_discrete_out_one,
  input wire logic o_discrete_out_two,
  input wire logic o_run_led,
  input wire logic o_do_one_led,
  input wire logic o_do_two_led
);
  // ****
  // Checks
  // ****
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [31:0] on_cnt_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !o_fire[0]) begin
      on_cnt_q <= '0;
    end else begin
      on_cnt_q <= on_cnt_q + 32'h1;
    end
  end
  halt_inhibit_a: assert property (o_cpu_halt == o_io_inhibit)
    else $error("halt and inhibit differ");
  inhibit_off_a: assert property (o_io_inhibit && $past(o_io_inhibit) |->
    o_fire == '0 && o_full_current == '0 && o_drive_gate == '0 && !o_discrete_out_one)
    else $error("output active during inhibit");
  run_dark_a: assert property (o_cpu_halt && $past(o_cpu_halt) |-> !o_run_led)
    else $error("run led lit while halted");
  run_lit_a: assert property (!o_cpu_halt [*3] |-> o_run_led)
    else $error("run led dark while running");
  do_led_a: assert property (o_do_one_led == o_discrete_out_one && o_do_two_led == o_discrete_out_two)
    else $error("discrete led mismatch");
  pull_gate_a: assert property ((o_full_current & ~(o_fire & o_drive_gate)) == '0)
    else $error("pull current without fire and gate");
  fire_start_a: assert property ((o_fire & ~$past(o_fire) & ~o_full_current) == '0)
    else $error("fire started without pull current");
  quiet_off_a: assert property ((i_inj_line == '0) [*8] |-> o_fire == '0)
    else $error("fire without command");
  line_fire_a: assert property ($rose(i_inj_line[0]) && !o_io_inhibit |->
    ##[2:8] (o_fire[1:0] != 2'b00 || o_io_inhibit))
    else $error("line zero not routed to its pair");
  hold_limit_a: assert property (o_fire[0] |-> on_cnt_q < HOLD_CYC)
    else $error("energize beyond hold limit");
  mmio_sel_a: assert property (i_reg_addr[7] && (i_reg_wr || i_reg_rd) |->
    o_mmio_wr == i_reg_wr && o_mmio_rd == i_reg_rd && o_mmio_sel == 4'(1 << i_reg_addr[6:5]))
    else $error("io select wrong");
  mark_pulse_a: assert property (o_top_center_mark |=> !o_top_center_mark)
    else $error("mark longer than one cycle");
  cover property ($fell(o_full_current[0]));
  cover property ($rose(o_cpu_halt));
  cover property (o_top_center_mark);
endmodule
bind ics_top ics_monitor #(.HOLD_CYC(HOLD_CYC), .TOOTH_CYC(TOOTH_CYC), .WDOG_CYC(WDOG_CYC)) ics_monitor_inst (
  .i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wr, .i_reg_rd, .o_mmio_sel, .o_mmio_wr, .o_mmio_rd, .i_inj_line,
  .o_fire, .o_full_current, .o_drive_gate, .o_top_center_mark, .o_cpu_halt, .o_io_inhibit, .o_discrete_out_one,
  .o_discrete_out_two, .o_run_led, .o_do_one_led, .o_do_two_led);

// ==== testbench/ics_cpu_model.sv ====
// Processor model that drives the shared injection lines.
`timescale 1ns/1ps
module ics_cpu_model
  import ics_pkg::*;
(
  // Clock and request
  input wire logic i_core_clk,
  input wire logic i_go,
  input wire logic [3:0] i_line,
  input wire logic [15:0] i_len,
  // Shared lines
  output logic [NUM_LINES-1:0] o_inj_line,
  output logic o_busy
);
  // ****
  // Event timing
  // ****
  logic [15:0] left_q = '0;
  initial begin
    o_inj_line = '0;
    o_busy = 1'b0;
  end
  always @(posedge i_core_clk) begin
    if (i_go && !o_busy) begin
      o_inj_line <= NUM_LINES'(1) << i_line;
      left_q <= i_len;
      o_busy <= 1'b1;
    end else if (left_q > 16'h1) begin
      left_q <= left_q - 16'h1;
    end else if (o_busy) begin
      o_inj_line <= '0;
      o_busy <= 1'b0;
    end
  end
endmodule

// ==== testbench/ics_top_tb.sv ====
// Self-checking bench for the injection command sequencer.
`timescale 1ns/1ps
module ics_top_tb
  import ics_pkg::*;
;
  // ****
  // Bench
  // ****
  localparam int HOLD = 12000;
  localparam int WDOG = 20000;
  localparam int TOOTH = 20;
  logic i_core_clk, i_rst_n, i_reg_wr, i_reg_rd, i_speed_pin, i_tdc_pin, i_phase_pin, i_cpu_restart;
  logic i_net_activity, o_speed_to_cpu, o_top_center_mark, o_cpu_halt, o_io_inhibit, o_run_led, o_net_led;
  logic o_discrete_out_one, o_discrete_out_two, o_do_one_led, o_do_two_led, o_irq, o_mmio_wr, o_mmio_rd, go;
  logic [3:0] o_mmio_sel, ln;
  logic [7:0] i_reg_addr;
  logic [15:0] len;
  logic [31:0] i_reg_wdata, o_reg_rdata, i_mmio_rdata;
  logic [NUM_LINES-1:0] i_inj_line;
  logic [NUM_CHAN-1:0] i_cur_over, o_fire, o_full_current, o_drive_gate;
  int errors, comparisons, marks, teeth, t, u, w;
  ics_top #(.HOLD_CYC(HOLD), .TOOTH_CYC(TOOTH), .WDOG_CYC(WDOG)) ics_top_inst (
    .i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_mmio_sel,
    .o_mmio_wr, .o_mmio_rd, .i_mmio_rdata, .i_inj_line, .i_speed_pin, .i_tdc_pin, .i_phase_pin, .i_cpu_restart,
    .i_net_activity, .i_cur_over, .o_speed_to_cpu, .o_top_center_mark, .o_fire, .o_full_current, .o_drive_gate,
    .o_cpu_halt, .o_io_inhibit, .o_discrete_out_one, .o_discrete_out_two, .o_run_led, .o_net_led,
    .o_do_one_led, .o_do_two_led, .o_irq);
  ics_cpu_model ics_cpu_model_inst (.i_core_clk, .i_go(go), .i_line(ln), .i_len(len), .o_inj_line(i_inj_line),
    .o_busy());
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  always @(negedge i_core_clk) begin
    marks += int'(o_top_center_mark === 1'b1);
    teeth += int'(o_speed_to_cpu === 1'b1);
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_core_clk);
    chk(n, e, o_reg_rdata);
    @(posedge i_core_clk);
  endtask
  function automatic logic probe(input int k, input int ch);
    case (k)
      0: return o_fire[ch];
      1: return o_full_current[ch];
      2: return o_drive_gate[ch];
      default: return o_cpu_halt;
    endcase
  endfunction
  task automatic waitv(input int k, input int ch, input logic v, input int lim, output int n);
    n = 0;
    while (probe(k, ch) !== v) begin
      @(posedge i_core_clk);
      n++;
      if (n > lim) begin
        errors++;
        $display("wrong value wait %0d expected %b seen %b", k, v, probe(k, ch));
        report_and_stop();
      end
    end
  endtask
  task automatic pulse(input int k, input int n);
    ln <= 4'(k);
    len <= 16'(n);
    go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
  endtask
  task automatic fire(input int k, input int n, input int ch);
    pulse(k, n);
    waitv(0, ch, 1'b1, 12, t);
    chk("pair", 0, 32'(o_fire[ch ^ 1]));
    rc(REG_CHAN_ACT, 32'h1 << ch, "active");
    waitv(0, ch, 1'b0, n + 12, t);
    chk("width", 1, 32'((t + 2 - n) ** 2 <= 4));
    cyc(10);
  endtask
  task automatic pin(input logic top_center_mark);
    i_tdc_pin <= top_center_mark;
    i_phase_pin <= !top_center_mark;
    cyc(6);
    i_tdc_pin <= 1'b0;
    i_phase_pin <= 1'b0;
    cyc(6);
  endtask
  initial begin
    {i_rst_n, i_reg_wr, i_reg_rd, i_speed_pin, i_tdc_pin, i_phase_pin, i_cpu_restart, i_net_activity, go} = '0;
    i_reg_addr = '0;
    i_reg_wdata = '0;
    i_mmio_rdata = '0;
    i_cur_over = '1;
    ln = '0;
    len = '0;
    cyc(4);
    i_rst_n <= 1'b1;
    cyc(2);
    chk("run led", 1, 32'(o_run_led));
    rc(REG_STAT, 0, "status");
    rc(REG_PULL, 32'(PULL_RST_UNITS), "pull");
    rc(8'h24, 0, "unmapped");
    rc(8'ha0, 0, "io read");
    wr(8'hc0, 32'h1);
    wr(REG_PULL, 32'h5);
    rc(REG_PULL, 32'h5, "pull low");
    wr(REG_PULL, 32'h50);
    rc(REG_PULL, 32'h50, "pull high");
    wr(REG_PULL, 32'h5);
    $display("test registers done");
    for (int k = 0; k < 2 * NUM_LINES; k++) begin
      fire(k / 2, 40, k);
    end
    $display("test demux done");
    wr(REG_KICK, 32'h1);
    wr(REG_IRQ_EN, 32'h1 << IRQ_LIMIT);
    pulse(0, HOLD + 200);
    waitv(0, 0, 1'b1, 12, t);
    waitv(1, 0, 1'b0, 10100, u);
    chk("pull time", 1, 32'((u - 10 * PULL_STEP_CYC_I) ** 2 <= 4));
    waitv(2, 0, 1'b0, 1600, w);
    chk("hold pwm", 1, 32'(o_fire[0]));
    waitv(0, 0, 1'b0, HOLD, t);
    chk("limit", 1, 32'((t + u + w - HOLD) ** 2 <= 9));
    cyc(20);
    chk("after limit", 0, 32'(o_fire[0]));
    chk("irq", 1, 32'(o_irq));
    rc(REG_IRQ_STAT, 32'h1 << IRQ_LIMIT, "irq status");
    wr(REG_IRQ_EN, 0);
    rc(REG_IRQ_EN, 0, "irq enable");
    chk("irq masked", 0, 32'(o_irq));
    wr(REG_IRQ_CLR, 32'h1 << IRQ_LIMIT);
    rc(REG_IRQ_STAT, 0, "irq cleared");
    cyc(200);
    $display("test pull and hold done");
    wr(REG_KICK, 32'h1);
    wr(REG_CTRL, 32'h1 << CTRL_RESYNC);
    fire(0, 40, 0);
    for (int v = 0; v < 4; v++) begin
      wr(REG_DOUT, 32'(v));
      cyc(2);
      chk("outputs", 32'(v), 32'({o_discrete_out_two, o_discrete_out_one}));
      chk("leds", 32'(v), 32'({o_do_two_led, o_do_one_led}));
    end
    i_net_activity <= 1'b1;
    cyc(8);
    chk("net led", 1, 32'(o_net_led));
    i_net_activity <= 1'b0;
    cyc(8);
    chk("net led off", 0, 32'(o_net_led));
    $display("test indicators done");
    u = marks;
    pin(0);
    pin(1);
    pin(1);
    chk("two stroke", 2, marks - u);
    wr(REG_CTRL, 32'h1 << CTRL_FOUR);
    u = marks;
    pin(1);
    pin(0);
    pin(1);
    pin(1);
    chk("four stroke", 1, marks - u);
    wr(REG_CTRL, 32'h1 << CTRL_TEST);
    cyc(3 * TOOTH);
    u = marks;
    w = teeth;
    cyc(TOOTH * SIM_TEETH);
    chk("teeth", SIM_TEETH, teeth - w);
    chk("wheel mark", 1, marks - u);
    wr(REG_CTRL, 0);
    $display("test timing marks done");
    wr(REG_KICK, 32'h1);
    waitv(3, 0, 1'b1, WDOG + 20, t);
    chk("watchdog time", 1, 32'((t - WDOG) ** 2 <= 25));
    cyc(2);
    chk("run led dark", 0, 32'(o_run_led));
    rc(REG_STAT, 32'h3, "halt status");
    wr(REG_DOUT, 32'h3);
    pulse(0, 40);
    cyc(50);
    chk("locked fire", 0, 32'(o_fire));
    chk("locked outputs", 0, 32'({o_discrete_out_two, o_discrete_out_one}));
    i_cpu_restart <= 1'b1;
    waitv(3, 0, 1'b0, 20, t);
    i_cpu_restart <= 1'b0;
    wr(REG_KICK, 32'h1);
    cyc(3);
    chk("run led back", 1, 32'(o_run_led));
    fire(0, 40, 0);
    $display("test watchdog done");
    report_and_stop();
  end
endmodule
